// file: src/bl_cfg_pkg.sv
// Package: register map, field layout and codes for the sync-lock and input-filter config block
`default_nettype none
package bl_cfg_pkg;
  // Register word indexes; the bus byte address is four times the index
  localparam logic [7:0] OFF_DIV_HIGH  = 8'ha6;
  localparam logic [7:0] OFF_DIV_LOW   = 8'ha7;
  localparam logic [7:0] OFF_CTRL      = 8'ha8;
  localparam logic [7:0] OFF_STATUS    = 8'ha9;
  // Field positions in the low register
  localparam int DIV_LOW_MSB   = 7;
  localparam int DIV_LOW_LSB   = 3;
  localparam int FRES_BIT      = 2;
  localparam int HYST_MSB      = 1;
  // Field positions in the control register
  localparam int SYNC_EN_BIT   = 0;
  localparam int RES_LSB       = 1;
  // Reset values
  localparam logic [7:0] DIV_HIGH_RST = 8'h00;
  localparam logic [7:0] DIV_LOW_RST  = 8'h00;
  localparam logic [2:0] CTRL_RST     = 3'h0;
  // Period factor N per resolution code (5, 10, 20, 40 MHz)
  localparam logic [7:0] N_5MHZ  = 8'h1a;
  localparam logic [7:0] N_10MHZ = 8'h32;
  localparam logic [7:0] N_20MHZ = 8'h62;
  localparam logic [7:0] N_40MHZ = 8'hc4;
  // PLL frequency per resolution code, in MHz
  localparam logic [5:0] F_5MHZ  = 6'h05;
  localparam logic [5:0] F_10MHZ = 6'h0a;
  localparam logic [5:0] F_20MHZ = 6'h14;
  localparam logic [5:0] F_40MHZ = 6'h28;

  typedef enum logic [1:0] {HYST_OFF, HYST_11B, HYST_10B, HYST_8B} hyst_mode_t;

  typedef struct packed {
    logic        sync_en;
    logic [12:0] div_count;
    logic [7:0]  n_factor;
    logic [5:0]  pll_mhz;
    logic        use_resistor;
  } pll_cfg_t;
endpackage : bl_cfg_pkg
`default_nettype wire

// file: src/bl_cfg_regs.sv
// Config register bank: PLL divider count, rate select and PWM input hysteresis
//
// Summary of operation
// - Divider high eight bits in first register
// - Divider low five bits in bits 7:3
// - Divider count used only when sync enabled
// - Bit 2 picks resistor or stored rate code
// - Hysteresis code selects filter resolution
// - Small input duty changes are ignored
// - Resolution code picks 5/10/20/40 MHz PLL
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module bl_cfg_regs #(
  parameter int DUTY_W = 13
) (
  input  wire logic                   mclk,
  input  wire logic                   nrst,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [9:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic [31:0]                 prdata,
  input  wire logic [DUTY_W-1:0]      duty_in,
  output logic [DUTY_W-1:0]           duty_out,
  output var bl_cfg_pkg::pll_cfg_t    pll_cfg
);
  // Narrower inputs cannot hold one step at 11-bit resolution
  if (DUTY_W < 11) begin : g_width_check
    $error("DUTY_W must be at least 11");
  end

  // ************************************************************
  // Register bank
  // ************************************************************
  logic [7:0] div_high_r, div_high_nxt;
  logic [7:0] div_low_r,  div_low_nxt;
  logic [2:0] ctrl_r,     ctrl_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        err_r,    err_nxt;
  logic        access;
  logic        hit;
  // Unaligned addresses map to index zero, where no register lives
  logic [7:0]  idx;
  assign idx = (paddr[1:0] == 2'b00) ? paddr[9:2] : 8'h00;

  assign access  = psel & penable;
  assign pready  = 1'b1;
  assign prdata  = prdata_r;
  assign pslverr = err_r & access;

  always_comb begin
    div_high_nxt = div_high_r;
    div_low_nxt  = div_low_r;
    ctrl_nxt     = ctrl_r;
    prdata_nxt   = 32'h0000_0000;
    hit          = 1'b1;
    if (idx == bl_cfg_pkg::OFF_DIV_HIGH) begin
      prdata_nxt = {24'h00_0000, div_high_r};
    end else if (idx == bl_cfg_pkg::OFF_DIV_LOW) begin
      prdata_nxt = {24'h00_0000, div_low_r};
    end else if (idx == bl_cfg_pkg::OFF_CTRL) begin
      prdata_nxt = {29'h0, ctrl_r};
    end else if (idx == bl_cfg_pkg::OFF_STATUS) begin
      prdata_nxt = {19'h0, pll_cfg.div_count};
    end else begin
      hit = 1'b0;
    end
    err_nxt = psel & ~penable & ~hit;
    if (psel & ~penable & ~pwrite) begin
      prdata_nxt = hit ? prdata_nxt : 32'h0000_0000;
    end else begin
      prdata_nxt = prdata_r;
    end
    if (access & pwrite) begin
      if (idx == bl_cfg_pkg::OFF_DIV_HIGH) begin
        div_high_nxt = pwdata[7:0];
      end else if (idx == bl_cfg_pkg::OFF_DIV_LOW) begin
        div_low_nxt = pwdata[7:0];
      end else if (idx == bl_cfg_pkg::OFF_CTRL) begin
        ctrl_nxt = pwdata[2:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      div_high_r <= bl_cfg_pkg::DIV_HIGH_RST;
      div_low_r  <= bl_cfg_pkg::DIV_LOW_RST;
      ctrl_r     <= bl_cfg_pkg::CTRL_RST;
      prdata_r   <= 32'h0000_0000;
      err_r      <= 1'b0;
    end else begin
      div_high_r <= div_high_nxt;
      div_low_r  <= div_low_nxt;
      ctrl_r     <= ctrl_nxt;
      prdata_r   <= prdata_nxt;
      err_r      <= err_nxt;
    end
  end

  // ************************************************************
  // PLL configuration decode
  // ************************************************************
  logic [1:0] res_code;
  logic       sync_en;
  assign res_code = ctrl_r[bl_cfg_pkg::RES_LSB +: 2];
  assign sync_en  = ctrl_r[bl_cfg_pkg::SYNC_EN_BIT];

  always_comb begin
    pll_cfg.sync_en = sync_en;
    // low five bits concatenated below high byte
    // count forced to zero while free running
    pll_cfg.div_count = sync_en ?
      {div_high_r, div_low_r[bl_cfg_pkg::DIV_LOW_MSB:bl_cfg_pkg::DIV_LOW_LSB]} : 13'h0;
    pll_cfg.use_resistor = div_low_r[bl_cfg_pkg::FRES_BIT];
    case (res_code)
      2'd0: begin
        pll_cfg.pll_mhz  = bl_cfg_pkg::F_5MHZ;
        pll_cfg.n_factor = bl_cfg_pkg::N_5MHZ;
      end
      2'd1: begin
        pll_cfg.pll_mhz  = bl_cfg_pkg::F_10MHZ;
        pll_cfg.n_factor = bl_cfg_pkg::N_10MHZ;
      end
      2'd2: begin
        pll_cfg.pll_mhz  = bl_cfg_pkg::F_20MHZ;
        pll_cfg.n_factor = bl_cfg_pkg::N_20MHZ;
      end
      default: begin
        pll_cfg.pll_mhz  = bl_cfg_pkg::F_40MHZ;
        pll_cfg.n_factor = bl_cfg_pkg::N_40MHZ;
      end
    endcase
  end

  // ************************************************************
  // PWM input hysteresis filter
  // ************************************************************
  bl_cfg_pkg::hyst_mode_t hyst_mode;
  logic [DUTY_W-1:0] duty_r, duty_nxt;
  logic [DUTY_W-1:0] step;
  logic [DUTY_W-1:0] diff;

  assign hyst_mode = bl_cfg_pkg::hyst_mode_t'(div_low_r[bl_cfg_pkg::HYST_MSB:0]);
  assign duty_out  = duty_r;

  always_comb begin
    // one LSB at the chosen resolution
    case (hyst_mode)
      bl_cfg_pkg::HYST_11B: step = DUTY_W'(1) << (DUTY_W - 11);
      bl_cfg_pkg::HYST_10B: step = DUTY_W'(1) << (DUTY_W - 10);
      bl_cfg_pkg::HYST_8B:  step = DUTY_W'(1) << (DUTY_W - 8);
      default:              step = '0;
    endcase
    diff = (duty_in > duty_r) ? duty_in - duty_r : duty_r - duty_in;
    // changes up to one step are ignored
    if (hyst_mode == bl_cfg_pkg::HYST_OFF || diff > step) begin
      duty_nxt = duty_in;
    end else begin
      duty_nxt = duty_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      duty_r <= '0;
    end else begin
      duty_r <= duty_nxt;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  chk_div_high_write: assert property (@(posedge mclk) disable iff (!nrst)
    access && pwrite && idx == bl_cfg_pkg::OFF_DIV_HIGH && ctrl_r[0]
    ##1 ctrl_r[0] |-> pll_cfg.div_count[12:5] == $past(pwdata[7:0]))
    else $error("High divider byte not applied");
  chk_div_low_join: assert property (@(posedge mclk) disable iff (!nrst)
    sync_en |-> pll_cfg.div_count[4:0] == div_low_r[7:3])
    else $error("Low divider bits misplaced");
  chk_free_run: assert property (@(posedge mclk) disable iff (!nrst)
    !sync_en |-> pll_cfg.div_count == 13'h0)
    else $error("Divider count used while free running");
  chk_rate_select: assert property (@(posedge mclk) disable iff (!nrst)
    nrst && access && pwrite && idx == bl_cfg_pkg::OFF_DIV_LOW |=> pll_cfg.use_resistor == $past(pwdata[2]))
    else $error("Rate select bit not applied");
  chk_hyst_off: assert property (@(posedge mclk) disable iff (!nrst)
    nrst && div_low_r[1:0] == 2'b00 |=> duty_out == $past(duty_in))
    else $error("Filter active while off");
  chk_hyst_hold: assert property (@(posedge mclk) disable iff (!nrst)
    nrst && div_low_r[1:0] == 2'b11 && diff <= step |=> $stable(duty_out))
    else $error("Small change passed the filter");
  chk_pll_freq: assert property (@(posedge mclk) disable iff (!nrst)
    res_code == 2'd3 |-> pll_cfg.pll_mhz == 6'h28 && pll_cfg.n_factor == 8'hc4)
    else $error("Wrong PLL frequency for resolution");
  chk_period_factor: assert property (@(posedge mclk) disable iff (!nrst)
    pll_cfg.n_factor == ((res_code == 2'd0) ? bl_cfg_pkg::N_5MHZ :
                         (res_code == 2'd1) ? bl_cfg_pkg::N_10MHZ :
                         (res_code == 2'd2) ? bl_cfg_pkg::N_20MHZ : bl_cfg_pkg::N_40MHZ))
    else $error("Wrong period factor for resolution");
  chk_read_back: assert property (@(posedge mclk) disable iff (!nrst)
    psel && !penable && !pwrite && idx == bl_cfg_pkg::OFF_DIV_LOW |=> prdata == {24'h00_0000, div_low_r})
    else $error("Read data wrong");
  chk_unmapped_err: assert property (@(posedge mclk) disable iff (!nrst)
    psel && !penable && !hit |=> !(psel && penable) || pslverr)
    else $error("Unmapped access not flagged");
  chk_err_gated: assert property (@(posedge mclk) disable iff (!nrst)
    !access |-> !pslverr)
    else $error("Error flag outside access phase");
  chk_status_ro: assert property (@(posedge mclk) disable iff (!nrst)
    nrst && access && pwrite && idx == bl_cfg_pkg::OFF_STATUS
    |=> $stable(div_high_r) && $stable(div_low_r) && $stable(ctrl_r))
    else $error("Status write changed a register");
endmodule : bl_cfg_regs
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the sync-lock and input-filter config registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                 mclk = 1'b0;
  logic                 nrst = 1'b0;
  logic                 psel = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite = 1'b0;
  logic [9:0]           paddr = 10'h000;
  logic [31:0]          pwdata = 32'h0;
  logic                 pready, pslverr, er;
  logic [31:0]          prdata, rd;
  logic [12:0]          duty_in = 13'h0;
  logic [12:0]          duty_out, exp_duty, b, step;
  logic [7:0]           hi, lo;
  logic [7:0]           nt [4] = '{8'h1a, 8'h32, 8'h62, 8'hc4};
  logic [2:0]           ctl;
  logic [1:0]           hc;
  bl_cfg_pkg::pll_cfg_t pll_cfg;
  int                   mismatches = 0;
  int                   num_checks = 0;
  int                   cyc = 0;
  integer               seed = 19;
  int                   fs;
  int                   span;
  logic [12:0]          cnt;

  bl_cfg_regs #(.DUTY_W(13)) dut (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .duty_in(duty_in), .duty_out(duty_out), .pll_cfg(pll_cfg));

  always #10 mclk = ~mclk;

  // A hang is cut short well past the expected run length
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Divider count that software programs for a resolution code and sync rate
  function automatic logic [12:0] div_for(input int r, input int fsync);
    return 13'((32'd5000000 << r) / (int'(nt[r]) * fsync));
  endfunction : div_for

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out

  // Request held until pready is seen high; answer taken at that edge
  task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic put(input logic [12:0] v);
    logic [12:0] d;
    @(posedge mclk);
    duty_in <= v;
    @(posedge mclk);
    #1;
    d = (v > exp_duty) ? v - exp_duty : exp_duty - v;
    if (hc == 2'h0 || d > step) exp_duty = v;
    chk("duty_out", duty_out, exp_duty);
  endtask : put

  initial begin
    exp_duty = 13'h0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    for (int a = 8'ha6; a <= 8'ha9; a++) begin
      apb(1'b0, {a[7:0], 2'b00}, 32'h0);
      chk("reset value", rd, 32'h0);
    end
    for (int i = 0; i < 8; i++) begin
      hi  = $random(seed);
      lo  = $random(seed);
      ctl = i[2:0];
      apb(1'b1, 10'h298, {24'h0, hi});
      apb(1'b1, 10'h29c, {24'h0, lo});
      apb(1'b1, 10'h2a0, {29'h0, ctl});
      apb(1'b1, 10'h2a4, $random(seed));
      chk("ro write err", er, 1'b0);
      apb(1'b1, 10'h2c0, $random(seed));
      chk("unmapped err", er, 1'b1);
      // Unaligned word address is refused and must not land
      apb(1'b1, 10'h299, $random(seed));
      chk("unaligned err", er, 1'b1);
      #1;
      chk("pslverr idle", pslverr, 1'b0);
      chk("sync_en", pll_cfg.sync_en, ctl[0]);
      chk("div_count", pll_cfg.div_count, ctl[0] ? {hi, lo[7:3]} : 13'h0);
      chk("use_resistor", pll_cfg.use_resistor, lo[2]);
      chk("pll_mhz", pll_cfg.pll_mhz, 6'h05 << ctl[2:1]);
      chk("n_factor", pll_cfg.n_factor, nt[ctl[2:1]]);
      apb(1'b0, 10'h298, 32'h0);
      chk("div high", rd, {24'h0, hi});
      apb(1'b0, 10'h29c, 32'h0);
      chk("div low", rd, {24'h0, lo});
      apb(1'b0, 10'h2a0, 32'h0);
      chk("control", rd, {29'h0, ctl});
      apb(1'b0, 10'h2a4, 32'h0);
      chk("status", rd, ctl[0] ? {19'h0, hi, lo[7:3]} : 32'h0);
    end
    for (int k = 0; k < 4; k++) begin
      hc   = k[1:0];
      step = (hc == 2'h0) ? 13'h0 : 13'h1 << ((hc == 2'h1) ? 2 : (hc == 2'h2) ? 3 : 5);
      apb(1'b1, 10'h29c, {30'h0, hc});
      put(duty_in);
      b = ($random(seed) & 13'h0fff) | 13'h0100;
      put(b);
      put(exp_duty + step);
      put(exp_duty + 13'h1);
      put(exp_duty - step - 13'h1);
    end
    // software count for a random sync rate at every resolution
    for (int r = 0; r < 4; r++) begin
      fs  = 60 + ($random(seed) & 63);
      cnt = div_for(r, fs);
      apb(1'b1, 10'h298, {24'h0, cnt[12:5]});
      apb(1'b1, 10'h29c, {24'h0, cnt[4:0], 3'h0});
      apb(1'b1, 10'h2a0, {29'h0, r[1:0], 1'b1});
      #1;
      chk("programmed count", pll_cfg.div_count, cnt);
      span = 1000000 * pll_cfg.pll_mhz / fs - pll_cfg.n_factor * pll_cfg.div_count;
      chk("sync span", span < pll_cfg.n_factor, 1'b1);
    end
    // Reset in mid-run clears the bank and the filter output
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk("duty reset", duty_out, 13'h0);
    chk("count reset", pll_cfg.div_count, 13'h0);
    @(posedge mclk);
    nrst <= 1'b1;
    for (int a = 8'ha6; a <= 8'ha9; a++) begin
      apb(1'b0, {a[7:0], 2'b00}, 32'h0);
      chk("reset value", rd, 32'h0);
    end
    close_out();
  end
endmodule : testbench
`default_nettype wire
